// *** core/psr_pkg.sv ***
// constants shared by the parallel/serial shift register
//
// Overview of operation
// (RL1) eight D stages chained, serial input feeds first
// (RL2) only stages six, seven, eight come out
// (RL3) select low: rising clock shifts chain once
// (RL4) select high: stages follow presets, clock ignored
// (RL5) stage n takes preset input n
// (RL6) contents hold while clock stands still
// (RL7) falling clock edge changes nothing
package psr_pkg;

  // ============================================================
  // geometry
  localparam int unsigned STAGE_COUNT = 8;
  localparam int unsigned TAP_SIX     = 5;
  localparam int unsigned TAP_SEVEN   = 6;
  localparam int unsigned TAP_EIGHT   = 7;

  // ============================================================
  // reset values
  localparam logic [STAGE_COUNT-1:0] STAGE_RESET = 8'h00;
  localparam logic                   PIN_RESET   = 1'h0;

  // ============================================================
  // pin conditioning
  localparam int unsigned SYNC_DEPTH = 3;

endpackage

// *** core/psr_shift_register.sv ***
// eight-stage parallel-load / serial-shift register with pin conditioning
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// pin synchroniser: three flops, a change counts once the
// second and third flops agree
module psr_pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             clockEnable,
  input  wire logic [WIDTH-1:0] pinIn,
  output var  logic [WIDTH-1:0] levelOut
);
  import psr_pkg::*;

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] second_q;
  logic [WIDTH-1:0] third_q;
  logic [WIDTH-1:0] level_q;
  logic [WIDTH-1:0] level_d;

  // ============================================================
  // flop chain; meta_q is read only by second_q
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_q   <= {WIDTH{PIN_RESET}};
      second_q <= {WIDTH{PIN_RESET}};
      third_q  <= {WIDTH{PIN_RESET}};
    end else if (clockEnable) begin
      meta_q   <= pinIn;
      second_q <= meta_q;
      third_q  <= second_q;
    end
  end

  // ============================================================
  // agreement filter, bit by bit
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      level_d[i] = (second_q[i] == third_q[i]) ? third_q[i] : level_q[i];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      level_q <= {WIDTH{PIN_RESET}};
    end else if (clockEnable) begin
      level_q <= level_d;
    end
  end

  assign levelOut = level_q;

endmodule

// ============================================================
// one storage stage: a plain D flop choosing load, shift or hold
module psr_stage #(
  parameter logic RESET_VALUE = psr_pkg::STAGE_RESET[0]
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic clockEnable,
  input  wire logic loadSelect,
  input  wire logic shiftStrobe,
  input  wire logic presetBit,
  input  wire logic serialBit,
  output var  logic stateOut
);
  import psr_pkg::*;

  logic stage_q;
  logic stage_d;

  // ============================================================
  // next value; a load outranks a shift strobe in the same cycle
  // hold is the default, so a stopped shift clock keeps the bit
  always_comb begin
    stage_d = stage_q; // hold while the clock stands  (see RL6)
    if (loadSelect) begin
      // clock and serial data ignored while loading
      stage_d = presetBit; // (see RL4) (see RL5)
    end else if (shiftStrobe) begin
      stage_d = serialBit; // (see RL3)
    end
  end

  // ============================================================
  // storage; no pin reset exists, the system reset clears it
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      stage_q <= RESET_VALUE;
    end else if (clockEnable) begin
      stage_q <= stage_d; // (see RL1)
    end
  end

  assign stateOut = stage_q;

endmodule

// ============================================================
// top: the register chain
module psr_shift_register #(
  parameter int unsigned STAGES = psr_pkg::STAGE_COUNT
) (
  input  wire logic                           clock,
  input  wire logic                           reset_n,
  input  wire logic                           clockEnable,
  input  wire logic                           shiftClock,
  input  wire logic                           loadShiftSelect,
  input  wire logic                           serialIn,
  input  wire logic [psr_pkg::STAGE_COUNT-1:0] presetInput,
  output var  logic                           stageSixOut,
  output var  logic                           stageSevenOut,
  output var  logic                           stageEightOut
);
  import psr_pkg::*;

  // ============================================================
  // conditioned pin levels
  logic                   shiftClockLvl;
  logic                   loadSelectLvl;
  logic                   serialLvl;
  logic [STAGES-1:0]      presetLvl;
  logic                   shiftClockPrev_q;
  logic                   shiftRise;
  logic [STAGES-1:0]      stageBits;
  logic [STAGES-1:0]      shifted;

  // all inputs share one conditioning depth, so data and clock
  // stay aligned and setup at the pins carries over
  psr_pin_sync #(
    .WIDTH (1)
  ) uClockSync (
    .clock       (clock),
    .reset_n     (reset_n),
    .clockEnable (clockEnable),
    .pinIn       (shiftClock),
    .levelOut    (shiftClockLvl)
  );

  psr_pin_sync #(
    .WIDTH (1)
  ) uSelectSync (
    .clock       (clock),
    .reset_n     (reset_n),
    .clockEnable (clockEnable),
    .pinIn       (loadShiftSelect),
    .levelOut    (loadSelectLvl)
  );

  psr_pin_sync #(
    .WIDTH (1)
  ) uSerialSync (
    .clock       (clock),
    .reset_n     (reset_n),
    .clockEnable (clockEnable),
    .pinIn       (serialIn),
    .levelOut    (serialLvl)
  );

  psr_pin_sync #(
    .WIDTH (STAGES)
  ) uPresetSync (
    .clock       (clock),
    .reset_n     (reset_n),
    .clockEnable (clockEnable),
    .pinIn       (presetInput[STAGES-1:0]),
    .levelOut    (presetLvl)
  );

  // ============================================================
  // shift clock edge tracking
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      shiftClockPrev_q <= PIN_RESET;
    end else if (clockEnable) begin
      shiftClockPrev_q <= shiftClockLvl;
    end
  end

  // rising only; a falling level gives no event  (see RL7)
  assign shiftRise = shiftClockLvl & ~shiftClockPrev_q;

  // ============================================================
  // per-stage next value
  assign shifted[0] = serialLvl; // (see RL1)

  for (genvar g = 1; g < STAGES; g++) begin : gChain
    assign shifted[g] = stageBits[g-1]; // (see RL3)
  end

  // one stage per bit; load has priority inside each stage, and a
  // rise seen while loading is dropped rather than replayed later,
  // so leaving load needs the shift clock held steady
  for (genvar g = 0; g < STAGES; g++) begin : gStage
    psr_stage #(
      .RESET_VALUE (STAGE_RESET[g])
    ) uStage (
      .clock       (clock),
      .reset_n     (reset_n),
      .clockEnable (clockEnable),
      .loadSelect  (loadSelectLvl),
      .shiftStrobe (shiftRise),
      .presetBit   (presetLvl[g]),
      .serialBit   (shifted[g]),
      .stateOut    (stageBits[g])
    );
  end

  // ============================================================
  // taps: only the last three stages leave the block
  assign stageSixOut   = stageBits[TAP_SIX];   // (see RL2)
  assign stageSevenOut = stageBits[TAP_SEVEN]; // (see RL2)
  assign stageEightOut = stageBits[TAP_EIGHT]; // (see RL2)

endmodule

`default_nettype wire

// *** tb/psr_props.sv ***
// assertion checker for the shift register pins
`timescale 1ns/1ps
`default_nettype none
module psr_props (
  input wire logic       clock, reset_n, clockEnable, shiftClock, loadShiftSelect, serialIn,
  input wire logic [7:0] presetInput,
  input wire logic       stageSixOut, stageSevenOut, stageEightOut
);
  wire logic [2:0] q = {stageEightOut, stageSevenOut, stageSixOut};
  wire logic ld = clockEnable && loadShiftSelect;
  wire logic sh = clockEnable && !loadShiftSelect;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // ==========================================================
  // windows of six or seven edges cover the pin filter delay
  a_load_taps: assert property ((ld && $stable(presetInput))[*7] |-> q == presetInput[7:5])
    else $error("load taps");
  a_load_still: assert property ((ld && $stable(presetInput))[*7] |-> $stable(q))
    else $error("load moved");
  a_shift_seven: assert property (sh && $rose(shiftClock) ##1 sh[*5] |-> stageSevenOut == $past(stageSixOut))
    else $error("stage seven");
  a_shift_eight: assert property (sh && $rose(shiftClock) ##1 sh[*5] |-> stageEightOut == $past(stageSevenOut))
    else $error("stage eight");
  a_fall_holds: assert property (sh && $fell(shiftClock) ##1 sh[*5] |-> $stable(q))
    else $error("fall moved");
  a_static_hold: assert property ((sh && $stable(shiftClock))[*7] |-> $stable(q))
    else $error("static moved");
  a_reset_clear: assert property ($rose(reset_n) |-> q == 3'h0)
    else $error("reset taps");
  c_shift: cover property (sh && $rose(shiftClock));
  c_load: cover property (ld && $changed(presetInput));
  c_fall: cover property (sh && $fell(shiftClock));
endmodule
bind psr_shift_register psr_props u_props (.clock, .reset_n, .clockEnable, .shiftClock, .loadShiftSelect,
  .serialIn, .presetInput, .stageSixOut, .stageSevenOut, .stageEightOut);
`default_nettype wire

// *** tb/psr_host_model.sv ***
// host-side model that drives the register pins
`timescale 1ns/1ps
`default_nettype none
module psr_host_model (
  input  wire logic       clock,
  output var  logic       shiftClock = 1'h0, loadShiftSelect = 1'h0, serialIn = 1'h0,
  output var  logic [7:0] presetInput = 8'h00
);
  // levels held n falling edges; n of 3 or more outlasts the pin filter
  task set(logic s, logic c, logic d, logic [7:0] p, int n);
    loadShiftSelect = s;
    shiftClock = c;
    serialIn = d;
    presetInput = p;
    repeat (n) @(negedge clock);
  endtask
endmodule
`default_nettype wire

// *** tb/test_parallel_serial_shift_register.sv ***
// self-checking bench for the shift register
`timescale 1ns/1ps
`default_nettype none
module test_parallel_serial_shift_register;
  logic clock = 1'h0, reset_n = 1'h0, clockEnable = 1'h1;
  logic shiftClock, loadShiftSelect, serialIn, stageSixOut, stageSevenOut, stageEightOut;
  logic [7:0] presetInput, m;
  int errCount = 0, nCompared = 0;
  initial forever #2.5 clock = ~clock;
  psr_shift_register DUT (.clock, .reset_n, .clockEnable, .shiftClock, .loadShiftSelect, .serialIn,
    .presetInput, .stageSixOut, .stageSevenOut, .stageEightOut);
  psr_host_model host (.clock, .shiftClock, .loadShiftSelect, .serialIn, .presetInput);
  task chk(string s, logic [2:0] e);
    nCompared++;
    if ({stageEightOut, stageSevenOut, stageSixOut} !== e) begin
      errCount++;
      $display("[ERR] %s expected %h seen %h", s, e, {stageEightOut, stageSevenOut, stageSixOut});
    end
  endtask
  task shift(logic b);
    host.set(1'h0, 1'h0, b, m, 3);
    host.set(1'h0, 1'h1, b, m, 3);
    host.set(1'h0, 1'h0, ~b, m, 6);
    m = {m[6:0], b};
  endtask
  task t_load();
    chk("reset", 3'h0);
    host.set(1'h1, 1'h0, 1'h0, 8'hA5, 6);
    chk("load", 3'h5);
    host.set(1'h1, 1'h1, 1'h1, 8'h5A, 6);
    chk("track", 3'h2);
    $display("load done");
  endtask
  task t_shift();
    m = 8'hC6;
    host.set(1'h1, 1'h0, 1'h0, m, 6);
    host.set(1'h0, 1'h0, 1'h0, m, 6);
    for (int i = 0; i < 12; i++) begin
      chk("shift", m[7:5]);
      shift(i[1]);
    end
    $display("shift done");
  endtask
  task t_hold();
    host.set(1'h0, 1'h1, 1'h0, m, 40);
    chk("high", m[6:4]);
    host.set(1'h0, 1'h0, 1'h1, m, 40);
    chk("fall", m[6:4]);
    $display("hold done");
  endtask
  task t_freeze();
    clockEnable = 1'h0;
    host.set(1'h0, 1'h1, 1'h1, m, 12);
    chk("freeze", m[6:4]);
    clockEnable = 1'h1;
    host.set(1'h0, 1'h1, 1'h1, m, 8);
    chk("thaw", m[5:3]);
    $display("freeze done");
  endtask
  task finishTest();
    $display("%0d checks, %0d errors", nCompared, errCount);
    if (errCount == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge clock);
    reset_n = 1'h1;
    @(negedge clock);
    t_load();
    t_shift();
    t_hold();
    t_freeze();
    finishTest();
  end
  // whole run is about 1.4 us
  initial begin
    #20us;
    errCount++;
    finishTest();
  end
endmodule
`default_nettype wire
